//--- hdl/pfs_pkg.sv
// pfs_pkg: constants and carrier types of the multiplexed pin function selector.
// assumes a byte-addressed register port and on-chip peripherals on the same clock.
`default_nettype none
package pfs_pkg;
  localparam int          NREG          = 7;
  localparam int          AW            = 27;
  // register indices
  localparam int          IDX_A_DIR     = 0;
  localparam int          IDX_B_DIR     = 1;
  localparam int          IDX_A_FN_UP   = 2;
  localparam int          IDX_A_FN_LO   = 3;
  localparam int          IDX_B_FN_UP   = 4;
  localparam int          IDX_B_FN_LO   = 5;
  localparam int          IDX_CAS_SEL   = 6;
  // byte offsets
  localparam logic [26:0] OFF_A_DIR     = 27'h5ffffc4;
  localparam logic [26:0] OFF_B_DIR     = 27'h5ffffc6;
  localparam logic [26:0] OFF_A_FN_UP   = 27'h5ffffc8;
  localparam logic [26:0] OFF_A_FN_LO   = 27'h5ffffca;
  localparam logic [26:0] OFF_B_FN_UP   = 27'h5ffffcc;
  localparam logic [26:0] OFF_B_FN_LO   = 27'h5ffffce;
  localparam logic [26:0] OFF_CAS_SEL   = 27'h5ffffee;
  localparam logic [26:0] REG_OFF [NREG] = '{OFF_A_DIR, OFF_B_DIR, OFF_A_FN_UP, OFF_A_FN_LO,
                                              OFF_B_FN_UP, OFF_B_FN_LO, OFF_CAS_SEL};
  // power-on reset values
  localparam logic [15:0] RST_A_DIR     = 16'h0000;
  localparam logic [15:0] RST_B_DIR     = 16'h0000;
  localparam logic [15:0] RST_A_FN_UP   = 16'h3302;
  localparam logic [15:0] RST_A_FN_LO   = 16'hff95;
  localparam logic [15:0] RST_B_FN_UP   = 16'h0000;
  localparam logic [15:0] RST_B_FN_LO   = 16'h0000;
  localparam logic [15:0] RST_CAS_SEL   = 16'h5fff;
  localparam logic [15:0] REG_RST [NREG] = '{RST_A_DIR, RST_B_DIR, RST_A_FN_UP, RST_A_FN_LO,
                                              RST_B_FN_UP, RST_B_FN_LO, RST_CAS_SEL};
  // access size codes
  localparam logic [1:0]  SZ_BYTE       = 2'h0;
  localparam logic [1:0]  SZ_HALF       = 2'h1;
  localparam logic [1:0]  SZ_WORD       = 2'h2;
  // function codes per pin
  localparam logic [1:0]  FN_PORT       = 2'h0;
  localparam logic [1:0]  FN_SECOND     = 2'h1;
  localparam logic [1:0]  FN_THIRD      = 2'h2;
  localparam logic [1:0]  FN_FOURTH     = 2'h3;
  // pins whose timer function follows the direction register
  localparam logic [15:0] A_TIMER_PINS  = 16'h0c05;
  localparam logic [15:0] B_TIMER_PINS  = 16'h003f;
  // strobe pins switched by the bus controller
  localparam int          STROBE_PIN_LO = 4;
  // column strobe select fields
  localparam int          CAS_HI_POS    = 14;
  localparam int          CAS_LO_POS    = 12;
  localparam logic [1:0]  CAS_USE_COL   = 2'h2;

  typedef struct packed {
    logic [15:0] out;
    logic [15:0] oe;
  } pfs_drive_type;
endpackage
`default_nettype wire

//--- hdl/pfs_top.sv
// pfs_top: function select, direction and routing of ports a, b and c.
// assumes RESET_N is the power-on reset only; manual reset and standby never reach it.
//
// Added by the designer: strobed register access.
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - While the converter runs every port c pin acts as its analog input channel.
// - The two bus strobe variants on pins a4 and a5 are chosen by the bus controller.
// - All registers read and write with byte, halfword and word accesses.
// - The port a upper function register loads 3302 hex at power-on reset.
// - The port a lower function register loads ff95 hex at power-on reset.
// - Both port b function registers reset to zero, selecting port function.
// - For port or timer functions a pin is an output when its direction bit is one.
// - Registers change only by software writes or power-on reset.
module pfs_top (
  input  wire logic                    CLK,
  input  wire logic                    RESET_N,
  input  wire logic [26:0]             ADDR,
  input  wire logic [1:0]              SIZE,
  input  wire logic [31:0]             WDATA,
  input  wire logic                    WR_EN,
  input  wire logic                    RD_EN,
  output logic      [31:0]             RDATA,
  input  wire logic [15:0]             PA_IN,
  output logic      [15:0]             PA_OUT,
  output logic      [15:0]             PA_OE,
  input  wire logic [15:0]             PB_IN,
  output logic      [15:0]             PB_OUT,
  output logic      [15:0]             PB_OE,
  input  wire logic [7:0]              PC_IN,
  input  wire pfs_pkg::pfs_drive_type [3:0] PA_SRC,
  input  wire pfs_pkg::pfs_drive_type [3:0] PB_SRC,
  output logic      [3:0][15:0]        PA_ROUTE_IN,
  output logic      [3:0][15:0]        PB_ROUTE_IN,
  output logic      [7:0]              PC_PORT_IN,
  input  wire logic                    ADC_ACTIVE,
  output logic      [7:0]              ANALOG_SEL,
  input  wire logic                    STROBE_MODE,
  input  wire logic [1:0]              PA_STROBE_ALT,
  output logic      [1:0]              CAS_PIN_SEL
);
  import pfs_pkg::*;

  logic [15:0] regs [NREG];
  logic [31:0] next_rdata;
  logic [15:0] pa_s1, pa_s2, pa_s3, pa_stable;
  logic [15:0] pb_s1, pb_s2, pb_s3, pb_stable;
  logic [7:0]  pc_s1, pc_s2, pc_s3, pc_stable;
  logic [31:0] fn_a, fn_b;
  logic [15:0] next_pa_out, next_pa_oe, next_pb_out, next_pb_oe;
  logic [2:0]  lane [NREG][2];

  assign fn_a = {regs[IDX_A_FN_UP], regs[IDX_A_FN_LO]};
  assign fn_b = {regs[IDX_B_FN_UP], regs[IDX_B_FN_LO]};

  // byte hit and data lane of a big-endian access, right-aligned data
  function automatic logic [2:0] lane_of(input logic [26:0] addr, input logic [1:0] size,
                                         input logic [26:0] baddr);
    logic [26:0] d;
    logic [2:0]  n;
    d = baddr - addr;
    n = (size == SZ_WORD) ? 3'h4 : ((size == SZ_HALF) ? 3'h2 : 3'h1);
    lane_of = 3'h0;
    if (baddr >= addr && d < 27'(n)) begin
      lane_of = {1'b1, 2'(n - 3'h1 - d[2:0])};
    end
  endfunction

  function automatic logic [1:0] code_of(input logic [31:0] fn, input int pin);
    code_of = fn[2*pin +: 2];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // register file; only the power-on reset reaches it
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int r = 0; r < NREG; r++) begin
        regs[r] <= REG_RST[r];
      end
    end else if (WR_EN) begin
      for (int r = 0; r < NREG; r++) begin
        for (int b = 0; b < 2; b++) begin
          if (lane[r][b][2]) begin
            regs[r][8*(1-b) +: 8] <= WDATA[8*lane[r][b][1:0] +: 8];
          end
        end
      end
    end
  end

  // lanes decoded once, shared by the write and the read path
  always_comb begin
    next_rdata = 32'h0;
    for (int r = 0; r < NREG; r++) begin
      for (int b = 0; b < 2; b++) begin
        lane[r][b] = lane_of(ADDR, SIZE, REG_OFF[r] + 27'(b));
        if (lane[r][b][2]) begin
          next_rdata[8*lane[r][b][1:0] +: 8] = regs[r][8*(1-b) +: 8];
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 32'h0;
    end else begin
      RDATA <= RD_EN ? next_rdata : 32'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers; a change counts once stages two and three agree
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {pa_s1, pa_s2, pa_s3, pa_stable} <= 64'h0;
      {pb_s1, pb_s2, pb_s3, pb_stable} <= 64'h0;
      {pc_s1, pc_s2, pc_s3, pc_stable} <= 32'h0;
    end else begin
      {pa_s1, pa_s2, pa_s3} <= {PA_IN, pa_s1, pa_s2};
      {pb_s1, pb_s2, pb_s3} <= {PB_IN, pb_s1, pb_s2};
      {pc_s1, pc_s2, pc_s3} <= {PC_IN, pc_s1, pc_s2};
      for (int i = 0; i < 16; i++) begin
        if (pa_s2[i] == pa_s3[i]) pa_stable[i] <= pa_s3[i];
        if (pb_s2[i] == pb_s3[i]) pb_stable[i] <= pb_s3[i];
      end
      for (int i = 0; i < 8; i++) begin
        if (pc_s2[i] == pc_s3[i]) pc_stable[i] <= pc_s3[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output drive selection
  always_comb begin
    logic [1:0] ca, cb;
    next_pa_out = 16'h0;
    next_pa_oe  = 16'h0;
    next_pb_out = 16'h0;
    next_pb_oe  = 16'h0;
    for (int i = 0; i < 16; i++) begin
      ca = code_of(fn_a, i);
      cb = code_of(fn_b, i);
      next_pa_out[i] = PA_SRC[ca].out[i];
      next_pb_out[i] = PB_SRC[cb].out[i];
      next_pa_oe[i]  = PA_SRC[ca].oe[i];
      next_pb_oe[i]  = PB_SRC[cb].oe[i];
      if (ca == FN_PORT || (ca == FN_THIRD && A_TIMER_PINS[i])) begin
        next_pa_oe[i] = regs[IDX_A_DIR][i];
      end
      if (cb == FN_PORT || (cb == FN_SECOND && B_TIMER_PINS[i])) begin
        next_pb_oe[i] = regs[IDX_B_DIR][i];
      end
      if ((i == STROBE_PIN_LO || i == STROBE_PIN_LO + 1) && ca == FN_SECOND && STROBE_MODE) begin
        next_pa_out[i] = PA_STROBE_ALT[i - STROBE_PIN_LO];
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      {PA_OUT, PA_OE, PB_OUT, PB_OE} <= 64'h0;
    end else begin
      {PA_OUT, PA_OE, PB_OUT, PB_OE} <= {next_pa_out, next_pa_oe, next_pb_out, next_pb_oe};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // input routing; unselected modules see zero
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PA_ROUTE_IN <= '0;
      PB_ROUTE_IN <= '0;
    end else begin
      for (int s = 0; s < 4; s++) begin
        for (int i = 0; i < 16; i++) begin
          PA_ROUTE_IN[s][i] <= (code_of(fn_a, i) == 2'(s)) & pa_stable[i];
          PB_ROUTE_IN[s][i] <= (code_of(fn_b, i) == 2'(s)) & pb_stable[i];
        end
      end
    end
  end

  // converter takes port c over without any register write
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ANALOG_SEL  <= 8'h0;
      PC_PORT_IN  <= 8'h0;
      CAS_PIN_SEL <= 2'h0;
    end else begin
      ANALOG_SEL  <= {8{ADC_ACTIVE}};
      PC_PORT_IN  <= ADC_ACTIVE ? 8'h0 : pc_stable;
      CAS_PIN_SEL <= {regs[IDX_CAS_SEL][CAS_HI_POS +: 2] == CAS_USE_COL,
                      regs[IDX_CAS_SEL][CAS_LO_POS +: 2] == CAS_USE_COL};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  logic first_cycle;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) first_cycle <= 1'b1;
    else          first_cycle <= 1'b0;
  end

  property p_analog;
    @(posedge CLK) disable iff (!RESET_N) ADC_ACTIVE |=> ANALOG_SEL == 8'hff && PC_PORT_IN == 8'h0;
  endproperty
  a_analog: assert property (p_analog) else $error("analog takeover missing");

  property p_strobe;
    @(posedge CLK) disable iff (!RESET_N)
      (fn_a[11:10] == FN_SECOND && STROBE_MODE) |=> PA_OUT[5] == $past(PA_STROBE_ALT[1]);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe variant wrong");

  property p_half_rw;
    @(posedge CLK) disable iff (!RESET_N)
      (WR_EN && ADDR == OFF_A_FN_UP && SIZE == SZ_HALF)
        |=> regs[IDX_A_FN_UP] == $past(WDATA[15:0]);
  endproperty
  a_half_rw: assert property (p_half_rw) else $error("halfword write lost");

  property p_read;
    @(posedge CLK) disable iff (!RESET_N)
      (RD_EN && ADDR == OFF_A_DIR && SIZE == SZ_WORD)
        |=> RDATA == {$past(regs[IDX_A_DIR]), $past(regs[IDX_B_DIR])};
  endproperty
  a_read: assert property (p_read) else $error("word read wrong");

  property p_rst_a_up;
    @(posedge CLK) disable iff (!RESET_N) first_cycle |-> regs[IDX_A_FN_UP] == RST_A_FN_UP;
  endproperty
  a_rst_a_up: assert property (p_rst_a_up) else $error("port a upper reset");

  property p_rst_a_lo;
    @(posedge CLK) disable iff (!RESET_N) first_cycle |-> regs[IDX_A_FN_LO] == RST_A_FN_LO;
  endproperty
  a_rst_a_lo: assert property (p_rst_a_lo) else $error("port a lower reset");

  property p_rst_b;
    @(posedge CLK) disable iff (!RESET_N) first_cycle |-> fn_b == 32'h0;
  endproperty
  a_rst_b: assert property (p_rst_b) else $error("port b reset");

  property p_dir;
    @(posedge CLK) disable iff (!RESET_N)
      fn_a[1:0] == FN_PORT |=> PA_OE[0] == $past(regs[IDX_A_DIR][0]);
  endproperty
  a_dir: assert property (p_dir) else $error("direction ignored");

  property p_hold;
    @(posedge CLK) disable iff (!RESET_N) !WR_EN |=> $stable(fn_a) && $stable(fn_b);
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without write");

  property p_route;
    @(posedge CLK) disable iff (!RESET_N) fn_b[1:0] == FN_PORT |=> PB_ROUTE_IN[1][0] == 1'b0;
  endproperty
  a_route: assert property (p_route) else $error("unselected module sees input");

  c_adc:    cover property (@(posedge CLK) disable iff (!RESET_N) $rose(ADC_ACTIVE));
  c_write:  cover property (@(posedge CLK) disable iff (!RESET_N) WR_EN && SIZE == SZ_BYTE);
  c_strobe: cover property (@(posedge CLK) disable iff (!RESET_N) STROBE_MODE && PA_OE[5]);
endmodule
`default_nettype wire

//--- sim/pfs_periph.sv
// pfs_periph: on-chip modules and package pins around the pin selector.
// assumes one clock domain; slot patterns and outside pin levels come from the bench.
`default_nettype none
module pfs_periph (
  input  wire logic [15:0]               pat,
  input  wire logic [15:0]               ext_a,
  input  wire logic [15:0]               ext_b,
  input  wire logic [15:0]               pa_out,
  input  wire logic [15:0]               pa_oe,
  input  wire logic [15:0]               pb_out,
  input  wire logic [15:0]               pb_oe,
  output var  pfs_pkg::pfs_drive_type [3:0] pa_src,
  output var  pfs_pkg::pfs_drive_type [3:0] pb_src,
  output logic      [15:0]               pa_in,
  output logic      [15:0]               pb_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import pfs_pkg::*;
  // each slot drives its own pattern, so a misrouted slot shows up at the pins
  always_comb begin
    for (int s = 0; s < 4; s++) begin
      pa_src[s].out = pat ^ 16'(16'h1111 * s);
      pa_src[s].oe  = ~pa_src[s].out;
      pb_src[s].out = pat ^ 16'(16'h1111 * s);
      pb_src[s].oe  = ~pb_src[s].out;
    end
  end
  // wire level: a driven pin reads back its own level, a released one the outside
  assign pa_in = (pa_oe & pa_out) | (~pa_oe & ext_a);
  assign pb_in = (pb_oe & pb_out) | (~pb_oe & ext_b);
endmodule
`default_nettype wire

//--- sim/tb.sv
// tb: self-checking bench of the pin function selector.
// assumes pfs_pkg and pfs_periph are compiled first; RESET_N is the power-on reset.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pfs_pkg::*;
  logic                CLK, RESET_N, WR_EN, RD_EN, STROBE_MODE, ADC_ACTIVE, rd_pend;
  logic [26:0]         ADDR;
  logic [1:0]          SIZE, PA_STROBE_ALT, CAS_PIN_SEL;
  logic [31:0]         WDATA, RDATA, e;
  logic [15:0]         PA_IN, PA_OUT, PA_OE, PB_IN, PB_OUT, PB_OE, pat, ext_a, ext_b, r, e16;
  logic [7:0]          PC_IN, PC_PORT_IN, ANALOG_SEL;
  logic [3:0][15:0]    PA_ROUTE_IN, PB_ROUTE_IN;
  pfs_drive_type [3:0] PA_SRC, PB_SRC;
  logic [31:0]         exp_q[$];
  int                  n_fail, check_count;
  //////////////////////////////////////////////////////////////////////////////
  pfs_top i_dut (.CLK(CLK), .RESET_N(RESET_N), .ADDR(ADDR), .SIZE(SIZE), .WDATA(WDATA),
    .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA), .PA_IN(PA_IN), .PA_OUT(PA_OUT),
    .PA_OE(PA_OE), .PB_IN(PB_IN), .PB_OUT(PB_OUT), .PB_OE(PB_OE), .PC_IN(PC_IN),
    .PA_SRC(PA_SRC), .PB_SRC(PB_SRC), .PA_ROUTE_IN(PA_ROUTE_IN),
    .PB_ROUTE_IN(PB_ROUTE_IN), .PC_PORT_IN(PC_PORT_IN), .ADC_ACTIVE(ADC_ACTIVE),
    .ANALOG_SEL(ANALOG_SEL), .STROBE_MODE(STROBE_MODE), .PA_STROBE_ALT(PA_STROBE_ALT),
    .CAS_PIN_SEL(CAS_PIN_SEL));
  pfs_periph i_periph (.pat(pat), .ext_a(ext_a), .ext_b(ext_b), .pa_out(PA_OUT),
    .pa_oe(PA_OE), .pb_out(PB_OUT), .pb_oe(PB_OE), .pa_src(PA_SRC), .pb_src(PB_SRC),
    .pa_in(PA_IN), .pb_in(PB_IN));
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // one bus cycle; for a read, d is the expected data and goes to the queue
  task automatic acc(input logic w, input logic [26:0] a, input logic [1:0] s,
                     input logic [31:0] d);
    @(posedge CLK);
    ADDR  <= a;
    SIZE  <= s;
    WDATA <= w ? d : 32'h0;
    WR_EN <= w;
    RD_EN <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge CLK);
    WR_EN <= 1'b0;
    RD_EN <= 1'b0;
  endtask
  task automatic stop_test();
    cyc(3);
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // read data stand one cycle only, so the monitor looks exactly then
  always @(posedge CLK) begin
    if (rd_pend) begin
      e = exp_q.pop_front();
      check_count++;
      if (RDATA !== e) begin
        n_fail++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, RDATA, e);
      end
    end
    rd_pend <= RD_EN;
  end
  initial begin
    cyc(20000);
    n_fail++;
    stop_test();
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {RESET_N, WR_EN, RD_EN, STROBE_MODE, ADC_ACTIVE} = 5'h00;
    {ADDR, SIZE, WDATA, PA_STROBE_ALT, PC_IN} = '0;
    {pat, ext_a, ext_b} = '0;
    r = 16'($urandom(10085));
    cyc(16);
    RESET_N <= 1'b1;
    for (int i = 0; i < NREG; i++) acc(1'b0, REG_OFF[i], SZ_HALF, {16'h0, REG_RST[i]});
    $display("test reset values done");
    for (int i = 0; i < NREG; i++) begin
      r = 16'($urandom);
      acc(1'b1, REG_OFF[i], SZ_HALF, {16'h0, r});
      acc(1'b0, REG_OFF[i], SZ_HALF, {16'h0, r});
    end
    acc(1'b1, OFF_A_FN_UP, SZ_WORD, 32'h1234abcd);
    acc(1'b1, OFF_A_FN_UP + 27'h1, SZ_BYTE, 32'h77);
    acc(1'b0, OFF_A_FN_UP, SZ_WORD, 32'h1277abcd);
    acc(1'b0, OFF_A_FN_LO, SZ_BYTE, 32'hab);
    acc(1'b0, OFF_A_DIR - 27'h4, SZ_HALF, 32'h0);
    $display("test access sizes done");
    // all pins on port function, random directions and patterns
    acc(1'b1, OFF_A_FN_UP, SZ_WORD, 32'h0);
    acc(1'b1, OFF_B_FN_UP, SZ_WORD, 32'h0);
    r = 16'($urandom);
    pat <= 16'($urandom);
    ext_a <= 16'($urandom);
    ext_b <= 16'($urandom);
    acc(1'b1, OFF_A_DIR, SZ_WORD, {r, ~r});
    cyc(8);
    chk(PA_OE, r);
    chk(PB_OE, ~r);
    chk(PA_OUT & r, pat & r);
    chk(PB_OUT & ~r, pat & ~r);
    chk(PA_ROUTE_IN[0], (r & pat) | (~r & ext_a));
    chk(PA_ROUTE_IN[1], 16'h0);
    chk(PB_ROUTE_IN[0], (~r & pat) | (r & ext_b));
    $display("test direction done");
    // lower port a pins onto slot 1; its oe is the inverse of its pattern
    acc(1'b1, OFF_A_FN_LO, SZ_HALF, 32'h5555);
    e16 = pat ^ 16'h1111;
    cyc(8);
    chk({8'h0, PA_OUT[7:0]}, {8'h0, e16[7:0]});
    chk({8'h0, PA_OE[7:0]}, {8'h0, ~e16[7:0]});
    chk({8'h0, PA_ROUTE_IN[1][7:0]}, {8'h0, e16[7:0] & ext_a[7:0]});
    chk({8'h0, PA_ROUTE_IN[0][7:0]}, 16'h0);
    // port b timer slot on pins 0..5 still follows the direction register
    acc(1'b1, OFF_B_FN_LO, SZ_HALF, 32'h0555);
    cyc(4);
    chk({8'h0, PB_OE[7:0]}, {8'h0, ~r[7:0]});
    chk({10'h0, PB_OUT[5:0]}, {10'h0, e16[5:0]});
    STROBE_MODE <= 1'b1;
    PA_STROBE_ALT <= 2'b10;
    cyc(3);
    chk({14'h0, PA_OUT[5:4]}, 16'h2);
    PA_STROBE_ALT <= 2'b01;
    cyc(3);
    chk({14'h0, PA_OUT[5:4]}, 16'h1);
    STROBE_MODE <= 1'b0;
    acc(1'b1, OFF_CAS_SEL, SZ_HALF, 32'h2000);
    cyc(3);
    chk({14'h0, CAS_PIN_SEL}, 16'h1);
    acc(1'b1, OFF_CAS_SEL, SZ_HALF, 32'h8000);
    cyc(3);
    chk({14'h0, CAS_PIN_SEL}, 16'h2);
    $display("test routing done");
    PC_IN <= 8'($urandom);
    cyc(8);
    chk({8'h0, PC_PORT_IN}, {8'h0, PC_IN});
    ADC_ACTIVE <= 1'b1;
    cyc(3);
    chk({8'h0, ANALOG_SEL}, 16'h00ff);
    chk({8'h0, PC_PORT_IN}, 16'h0);
    ADC_ACTIVE <= 1'b0;
    $display("test analog done");
    // a second power-on reset in mid-run must bring the reset values back
    acc(1'b1, OFF_A_FN_UP, SZ_WORD, 32'h0f0f0f0f);
    RESET_N <= 1'b0;
    cyc(16);
    RESET_N <= 1'b1;
    acc(1'b0, OFF_A_FN_UP, SZ_WORD, {RST_A_FN_UP, RST_A_FN_LO});
    $display("test second reset done");
    stop_test();
  end
endmodule
`default_nettype wire
